// ---- dv/rxdbg_host.sv ----
// Host model that issues register byte strobes to the bank.
`timescale 1ns/10ps
module rxdbg_host (
    input  wire logic             clk,
    output rxdbg_pkg::rxdbg_req_t req
);
    import rxdbg_pkg::*;
    initial req = '0;
    // Released address and data are inverted so stale values never match.
    task automatic xfer(input logic w, input logic r,
                        input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        req <= '{wr: w, rd: r, addr: a, wdata: d};
        @(posedge clk);
        req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask : xfer
endmodule : rxdbg_host

// ---- dv/rxdbg_regs_tb_top.sv ----
// Self-checking bench for the receive-port debug register bank.
`timescale 1ns/10ps
module rxdbg_regs_tb_top;
    import rxdbg_pkg::*;
    logic       clk = 1'b0, nrst = 1'b0, rdSeen = 1'b0;
    rxdbg_req_t req;
    logic [5:0] sel = '0;
    logic [3:0] raw = '0, vld = '0, bcf = '0, fsp, inj;
    logic [7:0] gom = '0, rdData, pdEn, dwell, pdDis, v;
    logic [7:0] expQ[$];
    int         num_errors = 0, comparisons = 0, cyc = 0, n;
    logic [7:0] adr[10] = '{8'hbb, 8'hbc, 8'hbd, 8'hbe, 8'hbf,
                            8'hc0, 8'hcf, 8'hd0, 8'hd1, 8'h10};
    logic [7:0] dfl[10] = '{8'h74, 8'h80, 8'h00, 8'h00, 8'h00,
                            8'h00, 8'h00, 8'h00, 8'h43, 8'h00};
    always #20 clk = ~clk;
    rxdbg_host rxdbg_host_inst (.clk(clk), .req(req));
    rxdbg_regs rxdbg_regs_inst (.clk(clk), .nrst(nrst), .regReq(req),
        .pageSelect(sel), .rawMode(raw), .frameValidLevel(vld),
        .backchanFrame(bcf), .gpioOutputMode(gom), .regRdData(rdData),
        .frameStartPulse(fsp), .backchanErrInject(inj),
        .pulldownEnable(pdEn), .frameValidMinDuration(dwell),
        .gpioPulldownDisable(pdDis));
    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        comparisons++;
        if (seen !== want) begin
            num_errors++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, want);
        end
    endtask : check
    task automatic print_verdict();
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : print_verdict
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        expQ.push_back(e);
        rxdbg_host_inst.xfer(1'b0, 1'b1, a, 8'h00);
    endtask : rd
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        rxdbg_host_inst.xfer(1'b1, 1'b0, a, d);
    endtask : wr
    // Sends one frame on every port and checks the injection strobes.
    task automatic frame(input logic [3:0] e);
        @(posedge clk);
        bcf <= 4'hf;
        @(posedge clk);
        bcf <= 4'h0;
        #1;
        check({4'h0, inj}, {4'h0, e});
    endtask : frame
    always @(posedge clk) begin
        if (rdSeen) check(rdData, expQ.pop_front());
        rdSeen <= req.rd;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 4000) begin
            num_errors++;
            print_verdict();
        end
    end
    initial begin
        void'($urandom(32'hcff66e44));
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        for (int k = 0; k < 10; k++) rd(adr[k], dfl[k]);
        for (int k = 0; k < 10; k++) if (!(k inside {1, 3, 7}))
            wr(adr[k], 8'hff);
        for (int k = 0; k < 10; k++) rd(adr[k], dfl[k]);
        v = 8'($urandom);
        wr(8'hbc, v);
        rd(8'hbc, v);
        check(dwell, v);
        v = 8'($urandom);
        gom <= 8'($urandom);
        wr(8'hbe, v);
        rd(8'hbe, v);
        check(pdDis, v);
        check(pdEn, ~(gom | v));
        sel <= 6'h05;
        wr(8'hd0, 8'hfe);
        sel <= 6'h02;
        wr(8'hd0, 8'h01);
        for (int k = 0; k < 4; k++) begin
            sel <= {2'(k), 4'h0};
            rd(8'hd0, k[0] ? {7'h0, ~k[1]} : 8'h02);
        end
        frame(4'b0111);
        frame(4'b0101);
        sel <= 6'h10;
        rd(8'hd0, 8'h00);
        sel <= 6'h0f;
        wr(8'hd0, 8'h00);
        frame(4'b0000);
        wr(8'hbc, 8'h05);
        raw <= 4'h1;
        vld <= 4'h3;
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (fsp !== 4'h1 && n < 50);
        check(8'(n), 8'h06);
        repeat (20) begin
            @(posedge clk);
            #1;
            check({4'h0, fsp}, 8'h00);
        end
        print_verdict();
    end
endmodule : rxdbg_regs_tb_top

// ---- hdl/rxdbg_consts.svh ----
// Offsets, field positions, reset values and fixed read values of the bank.
`ifndef RXDBG_CONSTS_SVH
`define RXDBG_CONSTS_SVH
`define RXDBG_OFS_RSVD_BB      8'hbb
`define RXDBG_OFS_DWELL        8'hbc
`define RXDBG_OFS_RSVD_BD      8'hbd
`define RXDBG_OFS_PD_DIS       8'hbe
`define RXDBG_OFS_RSVD_BF      8'hbf
`define RXDBG_OFS_RSVD_C0      8'hc0
`define RXDBG_OFS_RSVD_CF      8'hcf
`define RXDBG_OFS_ERR_INJ      8'hd0
`define RXDBG_OFS_RSVD_D1      8'hd1
`define RXDBG_VAL_RSVD_BB      8'h74
`define RXDBG_VAL_RSVD_BD      8'h00
`define RXDBG_VAL_RSVD_BF      8'h00
`define RXDBG_VAL_RSVD_C0      8'h00
`define RXDBG_VAL_RSVD_D1      8'h43
`define RXDBG_RST_DWELL        8'h80
`define RXDBG_RST_PD_DIS       8'h00
`define RXDBG_BIT_ERR_SINGLE   0
`define RXDBG_BIT_ERR_CONT     1
`define RXDBG_SEL_RD_LO        4
`define RXDBG_SEL_RD_HI        5
`define RXDBG_SEL_WR_LO        0
`define RXDBG_SEL_WR_HI        3
`define RXDBG_NUM_PORTS        4
`define RXDBG_NUM_GPIO         8
`endif

// ---- hdl/rxdbg_pkg.sv ----
// Types shared by the receive-port debug register bank.
package rxdbg_pkg;
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } rxdbg_req_t;

    typedef struct packed {
        logic [7:0]      dwell;
        logic [7:0]      pdDis;
        logic [3:0]      errCont;
        logic [3:0]      errSingle;
        logic [3:0][7:0] dwellCnt;
        logic [3:0]      dwellDone;
        logic [3:0]      errInject;
        logic [3:0]      frameStart;
        logic [7:0]      rdData;
    } rxdbg_state_t;
endpackage : rxdbg_pkg

// ---- hdl/rxdbg_regs.sv ----
// Receive-port debug and miscellaneous register bank with its controls.
`timescale 1ns/10ps
`include "rxdbg_consts.svh"
// Summary of operation
// R1: A raw-mode frame start waits until valid stayed high for the set count.
// R2: A GPIO pull-down is on while the pin is not an output, unless disabled.
// R3: Bit n of the disable register set to 1 removes the pull-down of pin n.
// R4: A paged read returns the copy of the port in page select bits 5:4.
// R5: A paged write updates each port whose page select bit n (3:0) is set.
// R6: Each receive port keeps its own copy of the debug register at 0xd0.
// R7: While continuous error is set, every back-channel frame gets an error.
// R8: A 1 written to single error injects one error, then the bit clears.
// R9: Reserved registers and fields read their fixed values and ignore writes.
module rxdbg_regs (
    input  wire logic                 clk,
    input  wire logic                 nrst,
    input  wire rxdbg_pkg::rxdbg_req_t regReq,
    input  wire logic [5:0]           pageSelect,
    input  wire logic [3:0]           rawMode,
    input  wire logic [3:0]           frameValidLevel,
    input  wire logic [3:0]           backchanFrame,
    input  wire logic [7:0]           gpioOutputMode,
    output logic      [7:0]           regRdData,
    output logic      [3:0]           frameStartPulse,
    output logic      [3:0]           backchanErrInject,
    output logic      [7:0]           pulldownEnable,
    output logic      [7:0]           frameValidMinDuration,
    output logic      [7:0]           gpioPulldownDisable
);
    import rxdbg_pkg::*;

    rxdbg_state_t st_r;
    rxdbg_state_t st_nxt;
    logic [1:0]   rdPort;
    logic [3:0]   wrPorts;
    logic         wrPage;

    assign rdPort  = pageSelect[`RXDBG_SEL_RD_HI:`RXDBG_SEL_RD_LO];
    assign wrPorts = pageSelect[`RXDBG_SEL_WR_HI:`RXDBG_SEL_WR_LO];
    assign wrPage  = regReq.wr && (regReq.addr == `RXDBG_OFS_ERR_INJ);

    always_comb begin
        st_nxt = st_r;
        if (regReq.wr && regReq.addr == `RXDBG_OFS_DWELL) begin
            st_nxt.dwell = regReq.wdata; // [R1]
        end
        if (regReq.wr && regReq.addr == `RXDBG_OFS_PD_DIS) begin
            st_nxt.pdDis = regReq.wdata; // [R3]
        end
        for (int p = 0; p < `RXDBG_NUM_PORTS; p++) begin
            // A pending single error is consumed by the next frame.
            st_nxt.errInject[p] = backchanFrame[p] &&
                (st_r.errCont[p] || st_r.errSingle[p]); // [R7] [R8]
            if (backchanFrame[p]) begin
                st_nxt.errSingle[p] = 1'b0; // [R8]
            end
            // A new write of 1 wins over the consumption in the same cycle.
            if (wrPage && wrPorts[p]) begin // [R5] [R6]
                st_nxt.errCont[p] = regReq.wdata[`RXDBG_BIT_ERR_CONT];
                if (regReq.wdata[`RXDBG_BIT_ERR_SINGLE]) begin
                    st_nxt.errSingle[p] = 1'b1; // [R8]
                end
            end
            st_nxt.frameStart[p] = 1'b0;
            if (!frameValidLevel[p] || !rawMode[p]) begin
                st_nxt.dwellCnt[p]  = 8'h00;
                st_nxt.dwellDone[p] = 1'b0;
            end else if (!st_r.dwellDone[p]) begin
                if (st_r.dwellCnt[p] == st_r.dwell) begin
                    st_nxt.frameStart[p] = 1'b1; // [R1]
                    st_nxt.dwellDone[p]  = 1'b1;
                end else begin
                    st_nxt.dwellCnt[p] = st_r.dwellCnt[p] + 8'h01; // [R1]
                end
            end
        end
        if (regReq.rd) begin
            // Reserved and unmapped offsets return constants only.
            if (regReq.addr >= `RXDBG_OFS_RSVD_C0 &&
                regReq.addr <= `RXDBG_OFS_RSVD_CF) begin
                st_nxt.rdData = `RXDBG_VAL_RSVD_C0; // [R9]
            end else begin
                case (regReq.addr)
                    `RXDBG_OFS_RSVD_BB: st_nxt.rdData = `RXDBG_VAL_RSVD_BB;
                    `RXDBG_OFS_DWELL:   st_nxt.rdData = st_r.dwell;
                    `RXDBG_OFS_RSVD_BD: st_nxt.rdData = `RXDBG_VAL_RSVD_BD;
                    `RXDBG_OFS_PD_DIS:  st_nxt.rdData = st_r.pdDis;
                    `RXDBG_OFS_RSVD_BF: st_nxt.rdData = `RXDBG_VAL_RSVD_BF;
                    `RXDBG_OFS_ERR_INJ: st_nxt.rdData = {6'h00,
                        st_r.errCont[rdPort], st_r.errSingle[rdPort]}; // [R4]
                    `RXDBG_OFS_RSVD_D1: st_nxt.rdData = `RXDBG_VAL_RSVD_D1;
                    default:            st_nxt.rdData = 8'h00; // [R9]
                endcase
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_r       <= '0;
            st_r.dwell <= `RXDBG_RST_DWELL;
            st_r.pdDis <= `RXDBG_RST_PD_DIS;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign regRdData             = st_r.rdData;
    assign frameStartPulse       = st_r.frameStart;
    assign backchanErrInject     = st_r.errInject;
    assign frameValidMinDuration = st_r.dwell;
    assign gpioPulldownDisable   = st_r.pdDis;
    assign pulldownEnable        = ~(gpioOutputMode | st_r.pdDis); // [R2]

    // Checks on the register paths and on the per-port controls.
    a_pulldown_map: assert property ( // [R2] [R3]
        @(posedge clk) disable iff (!nrst)
        regReq.wr && regReq.addr == `RXDBG_OFS_PD_DIS
        |=> pulldownEnable == ~(gpioOutputMode | $past(regReq.wdata)))
        else $error("pull-down enable does not follow mode and disable");

    a_dwell_write: assert property ( // [R1]
        @(posedge clk) disable iff (!nrst)
        regReq.wr && regReq.addr == `RXDBG_OFS_DWELL
        |=> frameValidMinDuration == $past(regReq.wdata))
        else $error("minimum valid duration not written");

    a_rsvd_read: assert property ( // [R9]
        @(posedge clk) disable iff (!nrst)
        regReq.rd && regReq.addr == `RXDBG_OFS_RSVD_D1
        |=> regRdData == `RXDBG_VAL_RSVD_D1)
        else $error("reserved register read wrong value");

    a_rsvd_bb_read: assert property ( // [R9]
        @(posedge clk) disable iff (!nrst)
        regReq.rd && regReq.addr == `RXDBG_OFS_RSVD_BB
        |=> regRdData == `RXDBG_VAL_RSVD_BB)
        else $error("reserved register at bb read wrong value");

    a_rsvd_block_read: assert property ( // [R9]
        @(posedge clk) disable iff (!nrst)
        regReq.rd && regReq.addr >= `RXDBG_OFS_RSVD_C0
        && regReq.addr <= `RXDBG_OFS_RSVD_CF
        |=> regRdData == `RXDBG_VAL_RSVD_C0)
        else $error("reserved block read wrong value");

    a_page_read: assert property ( // [R4] [R6]
        @(posedge clk) disable iff (!nrst)
        regReq.rd && regReq.addr == `RXDBG_OFS_ERR_INJ
        |=> regRdData[7:2] == 6'h00 &&
            regRdData[1] == $past(st_r.errCont[rdPort]) &&
            regRdData[0] == $past(st_r.errSingle[rdPort]))
        else $error("paged read returned wrong port copy");

    a_read_hold: assert property ( // [R4]
        @(posedge clk) disable iff (!nrst)
        !regReq.rd |=> $stable(regRdData))
        else $error("read data changed without a read");

    generate
        for (genvar g = 0; g < `RXDBG_NUM_PORTS; g++) begin : g_chk
            a_write_mask: assert property ( // [R5]
                @(posedge clk) disable iff (!nrst)
                !(wrPage && wrPorts[g])
                |=> st_r.errCont[g] == $past(st_r.errCont[g]))
                else $error("unselected port copy changed on write");

            a_cont_write: assert property ( // [R5] [R7]
                @(posedge clk) disable iff (!nrst)
                wrPage && wrPorts[g]
                |=> st_r.errCont[g] ==
                    $past(regReq.wdata[`RXDBG_BIT_ERR_CONT]))
                else $error("selected port copy missed the write");

            a_single_set: assert property ( // [R8]
                @(posedge clk) disable iff (!nrst)
                wrPage && wrPorts[g] && regReq.wdata[`RXDBG_BIT_ERR_SINGLE]
                |=> st_r.errSingle[g])
                else $error("single error request was lost");

            a_single_hold: assert property ( // [R5] [R8]
                @(posedge clk) disable iff (!nrst)
                !st_r.errSingle[g] && !(wrPage && wrPorts[g])
                |=> !st_r.errSingle[g])
                else $error("single error set without a write");

            a_cont_inject: assert property ( // [R7]
                @(posedge clk) disable iff (!nrst)
                st_r.errCont[g] && backchanFrame[g]
                |=> backchanErrInject[g])
                else $error("continuous error missing on frame");

            a_single_once: assert property ( // [R8]
                @(posedge clk) disable iff (!nrst)
                st_r.errSingle[g] && !st_r.errCont[g] && backchanFrame[g]
                && !(wrPage && wrPorts[g])
                |=> backchanErrInject[g] && !st_r.errSingle[g])
                else $error("single error not injected and cleared");

            a_no_inject: assert property ( // [R7] [R8]
                @(posedge clk) disable iff (!nrst)
                backchanErrInject[g]
                |-> $past(backchanFrame[g]) &&
                    ($past(st_r.errCont[g]) || $past(st_r.errSingle[g])))
                else $error("error injected without cause");

            a_fs_timing: assert property ( // [R1]
                @(posedge clk) disable iff (!nrst)
                frameStartPulse[g]
                |-> $past(frameValidLevel[g]) && $past(rawMode[g]) &&
                    $past(st_r.dwellCnt[g]) == $past(st_r.dwell))
                else $error("frame start before minimum duration");

            a_fs_single: assert property ( // [R1]
                @(posedge clk) disable iff (!nrst)
                frameStartPulse[g] |=> !frameStartPulse[g])
                else $error("frame start pulse longer than one cycle");

            a_fs_idle: assert property ( // [R1]
                @(posedge clk) disable iff (!nrst)
                !frameValidLevel[g] || !rawMode[g]
                |=> !frameStartPulse[g])
                else $error("frame start without raw-mode valid");
        end
    endgenerate
endmodule : rxdbg_regs
